/* dmrc_core.sv */
// dram address mux, bank strobe decode and refresh controller with apb
//
// Functional notes
// RULE1: nine-bit refresh counter supplies refresh rows
// RULE2: refresh drives counter onto address outputs
// RULE3: counter advances once per finished refresh
// RULE4: nine muxed addresses, four row strobes
// RULE5: access activates exactly one row strobe
// RULE6: input latches may stay transparent
// RULE7: two mode bits give four modes
// RULE8: latches follow high, capture on fall
// RULE9: chip select blocks access, not refresh
// RULE10: refresh lowers all row strobes, column high
// RULE11: bank code 00..11 maps strobe 0..3
// RULE12: pending refresh wins over new access
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dmrc_core
    import dmrc_pkg::*;
#(
    parameter int AW = ADDR_W
)
(
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // processor side
    input  wire logic [AW-1:0] row_address_in,
    input  wire logic [AW-1:0] column_address_in,
    input  wire logic          bank_select_low,
    input  wire logic          bank_select_high,
    input  wire logic          address_latch_strobe,
    input  wire logic          chip_select_n,
    input  wire logic          row_strobe_request_in_n,
    input  wire logic          column_strobe_request_in_n,
    input  wire logic          row_column_select,
    input  wire logic          write_request_in_n,
    // dram side
    output logic      [AW-1:0] muxed_address_out,
    output logic      [3:0]    row_strobe_out_n,
    output logic               column_strobe_out_n,
    output logic               write_enable_out_n
);

    // latched inputs
    logic [AW-1:0] row_q;
    logic [AW-1:0] col_q;
    logic [1:0]    bank_q;
    logic [AW-1:0] ref_count;

    // RULE6: row, column and bank latches
    dmrc_fall_latch #(.W(AW)) u_row_latch (
        .pclk    (pclk),
        .presetn (presetn),
        .strobe  (address_latch_strobe),
        .d       (row_address_in),
        .q       (row_q)
    );

    dmrc_fall_latch #(.W(AW)) u_col_latch (
        .pclk    (pclk),
        .presetn (presetn),
        .strobe  (address_latch_strobe),
        .d       (column_address_in),
        .q       (col_q)
    );

    // RULE11: high select is msb
    dmrc_fall_latch #(.W(2)) u_bank_latch (
        .pclk    (pclk),
        .presetn (presetn),
        .strobe  (address_latch_strobe),
        .d       ({bank_select_high, bank_select_low}),
        .q       (bank_q)
    );

    // state
    dmrc_state_t   state_reg, state_next;
    dmrc_mode_t    mode_reg, mode_next;
    logic [7:0]    timer_reg, timer_next;
    logic [15:0]   interval_reg, interval_next;
    logic [15:0]   ivl_cnt_reg, ivl_cnt_next;
    logic          pending_reg, pending_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic [3:0]    ras_reg, ras_next;
    logic          cas_reg, cas_next;
    logic          we_reg, we_next;
    logic [31:0]   prdata_reg, prdata_next;
    logic          ref_advance;
    logic          ref_start;
    logic          ref_due;
    logic          cnt_clear;
    logic          wr_access;
    logic          addr_ok;
    logic          access_mode;
    logic [3:0]    bank_onehot;

    // refresh counter
    dmrc_refresh_counter #(.W(AW)) u_ref_counter (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (cnt_clear),
        .advance (ref_advance),
        .count   (ref_count)
    );

    // RULE7: mode decode
    assign access_mode = (mode_reg == MODE_EXT_ACC) ||
                         (mode_reg == MODE_AUTO_ACC);
    // RULE11: binary bank decode
    assign bank_onehot = 4'h1 << bank_q;

    // apb decode; zero wait states
    assign wr_access = psel && penable && pwrite;
    assign addr_ok   = (paddr == CTRL_OFS) || (paddr == STATUS_OFS) ||
                       (paddr == INTERVAL_OFS);
    assign pready    = psel && penable;
    assign pslverr   = psel && penable && !addr_ok;
    assign prdata    = prdata_reg;
    assign cnt_clear = wr_access && (paddr == CTRL_OFS) &&
                       pwdata[CTRL_CLEAR_BIT];

    // register file next values
    always_comb
    begin
        mode_next     = mode_reg;
        interval_next = interval_reg;
        prdata_next   = prdata_reg;
        if (wr_access && paddr == CTRL_OFS)
            mode_next = dmrc_mode_t'({pwdata[CTRL_MODE_B_BIT],
                                      pwdata[CTRL_MODE_A_BIT]});
        if (wr_access && paddr == INTERVAL_OFS && pwdata[15:0] != 16'h0)
            interval_next = pwdata[15:0];
        // read data sampled in the setup phase
        if (psel && !penable && !pwrite)
        begin
            prdata_next = 32'h0;
            case (paddr)
                CTRL_OFS:
                begin
                    prdata_next[CTRL_MODE_B_BIT] = mode_reg[1];
                    prdata_next[CTRL_MODE_A_BIT] = mode_reg[0];
                end
                STATUS_OFS:
                begin
                    prdata_next[STAT_COUNT_LSB +: AW]  = ref_count;
                    prdata_next[STAT_STATE_LSB +: 3]   = state_reg;
                    prdata_next[STAT_PENDING_BIT]      = pending_reg;
                end
                INTERVAL_OFS: prdata_next[15:0] = interval_reg;
                default:      prdata_next = 32'h0;
            endcase
        end
    end

    // refresh interval timer
    always_comb
    begin
        ref_due      = 1'b0;
        ivl_cnt_next = ivl_cnt_reg + 16'h1;
        if (ivl_cnt_reg >= interval_reg - 16'h1)
        begin
            ivl_cnt_next = 16'h0;
            ref_due      = (mode_reg != MODE_EXT_REF);
        end
        // set wins over the clear taken by a starting refresh
        pending_next = (pending_reg && !ref_start) || ref_due;
    end

    // sequencer next state
    always_comb
    begin
        state_next  = state_reg;
        timer_next  = timer_reg;
        ref_start   = 1'b0;
        ref_advance = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                timer_next = 8'h0;
                if (mode_reg == MODE_EXT_REF)
                begin
                    // RULE9: refresh ignores chip select
                    if (!row_strobe_request_in_n)
                    begin
                        state_next = ST_REF;
                        ref_start  = 1'b1;
                    end
                end
                // RULE12: refresh before access
                else if (pending_reg)
                begin
                    state_next = ST_REF;
                    ref_start  = 1'b1;
                end
                // RULE9: chip select gates access
                else if (access_mode && !chip_select_n &&
                         !row_strobe_request_in_n)
                    state_next = ST_ROW;
            end
            ST_REF:
            begin
                timer_next = timer_reg + 8'h1;
                // RULE3: advance on completion
                if (mode_reg == MODE_EXT_REF)
                begin
                    if (row_strobe_request_in_n)
                    begin
                        state_next  = ST_IDLE;
                        ref_advance = 1'b1;
                    end
                end
                else if (timer_reg >= REF_PULSE_CYC - 8'h1)
                begin
                    state_next  = ST_IDLE;
                    ref_advance = 1'b1;
                end
            end
            ST_ROW:
            begin
                timer_next = timer_reg + 8'h1;
                if (row_strobe_request_in_n)
                    state_next = ST_IDLE;
                else if (mode_reg == MODE_EXT_ACC ? !row_column_select :
                         timer_reg >= ROW_HOLD_CYC - 8'h1)
                begin
                    state_next = ST_COL;
                    timer_next = 8'h0;
                end
            end
            ST_COL:
            begin
                if (timer_reg != 8'hff)
                    timer_next = timer_reg + 8'h1;
                if (row_strobe_request_in_n)
                    state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // dram outputs from the next state
    always_comb
    begin
        we_next  = write_request_in_n;
        cas_next = 1'b1;
        ras_next = 4'hf;
        addr_next = row_q;
        case (state_next)
            // RULE2: counter on address outputs
            ST_REF:
            begin
                addr_next = ref_count;
                // RULE10: all row strobes low
                ras_next  = 4'h0;
            end
            // RULE5: only selected strobe low
            ST_ROW: ras_next = ~bank_onehot;
            ST_COL:
            begin
                // RULE4: column latch to outputs
                addr_next = col_q;
                ras_next  = ~bank_onehot;
                if (mode_reg == MODE_EXT_ACC)
                    cas_next = column_strobe_request_in_n;
                else
                    cas_next = !(timer_next >= COL_SETUP_CYC);
            end
            default: ras_next = 4'hf;
        endcase
    end

    // all registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg    <= ST_IDLE;
            mode_reg     <= dmrc_mode_t'(CTRL_MODE_RESET);
            timer_reg    <= 8'h0;
            interval_reg <= REF_INTERVAL_CYC;
            ivl_cnt_reg  <= 16'h0;
            pending_reg  <= 1'b0;
            addr_reg     <= '0;
            ras_reg      <= 4'hf;
            cas_reg      <= 1'b1;
            we_reg       <= 1'b1;
            prdata_reg   <= 32'h0;
        end
        else
        begin
            state_reg    <= state_next;
            mode_reg     <= mode_next;
            timer_reg    <= timer_next;
            interval_reg <= interval_next;
            ivl_cnt_reg  <= ivl_cnt_next;
            pending_reg  <= pending_next;
            addr_reg     <= addr_next;
            ras_reg      <= ras_next;
            cas_reg      <= cas_next;
            we_reg       <= we_next;
            prdata_reg   <= prdata_next;
        end
    end

    assign muxed_address_out   = addr_reg;
    assign row_strobe_out_n    = ras_reg;
    assign column_strobe_out_n = cas_reg;
    assign write_enable_out_n  = we_reg;

    a_ref_address: assert property (  // RULE2
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_REF) |-> (muxed_address_out == ref_count))
        else $error("refresh row not on address outputs");

    a_ref_strobes: assert property (  // RULE10
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_REF) |-> (row_strobe_out_n == 4'h0 &&
                                   column_strobe_out_n))
        else $error("refresh strobes wrong");

    a_one_bank: assert property (  // RULE5
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_ROW || state_reg == ST_COL) |->
            $onehot(~row_strobe_out_n))
        else $error("access strobe not one-hot");

    a_bank_map: assert property (  // RULE11
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_ROW && $stable(bank_q)) |->
            (row_strobe_out_n == ~(4'h1 << bank_q)))
        else $error("bank select mapped to wrong strobe");

    a_cs_blocks: assert property (  // RULE9
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_IDLE && chip_select_n) |=> (state_reg != ST_ROW))
        else $error("access started with chip select high");

    a_ref_first: assert property (  // RULE12
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_IDLE && pending_reg && access_mode) |=>
            (state_reg == ST_REF))
        else $error("access taken ahead of pending refresh");

    a_row_hold: assert property (  // RULE4
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_ROW && mode_reg == MODE_AUTO_ACC &&
         timer_reg == ROW_HOLD_CYC - 8'h1 && !row_strobe_request_in_n)
        |=> (state_reg == ST_COL) ##0 (muxed_address_out == $past(col_q)))
        else $error("column not switched after row hold");

    a_auto_ref_len: assert property (  // RULE3
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_REF && mode_reg == MODE_AUTO_REF &&
         $stable(mode_reg)) |-> (timer_reg < REF_PULSE_CYC))
        else $error("auto refresh overran its pulse");

endmodule // dmrc_core
`default_nettype wire

/* dmrc_dram_model.sv */
// passive dram bank model reporting each row or column strobe fall
`timescale 1ns/1ps
`default_nettype none
module dmrc_dram_model
    import dmrc_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // dram pins
    input  wire logic [ADDR_W-1:0] muxed_address_out,
    input  wire logic [3:0]        row_strobe_out_n,
    input  wire logic              column_strobe_out_n,
    // captured record {column flag, row strobes, address}
    output logic                   cap_valid,
    output logic      [13:0]       cap_data
);
    logic [3:0] ras_prev_reg;
    logic [3:0] ras_prev_next;
    logic       cas_prev_reg;
    logic       cas_prev_next;
    logic       col_fall;

    // remember last strobe levels
    always_comb
    begin
        ras_prev_next = row_strobe_out_n;
        cas_prev_next = column_strobe_out_n;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ras_prev_reg <= 4'hf;
            cas_prev_reg <= 1'b1;
        end
        else
        begin
            ras_prev_reg <= ras_prev_next;
            cas_prev_reg <= cas_prev_next;
        end
    end

    // a bank opens its row or column on the strobe fall
    always_comb
    begin
        col_fall  = cas_prev_reg && !column_strobe_out_n;
        cap_valid = (ras_prev_reg == 4'hf && row_strobe_out_n != 4'hf)
                    || col_fall;
        cap_data  = {col_fall, row_strobe_out_n, muxed_address_out};
    end
endmodule // dmrc_dram_model
`default_nettype wire

/* dmrc_fall_latch.sv */
// fall-through input latch, transparent while its strobe is high
`timescale 1ns/1ps
`default_nettype none
module dmrc_fall_latch
    import dmrc_pkg::*;
#(
    parameter int W = 9
)
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // latch control and data
    input  wire logic         strobe,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] held_reg;
    logic [W-1:0] held_next;

    // RULE8: follow while high
    always_comb
    begin
        held_next = strobe ? d : held_reg;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            held_reg <= '0;
        else
            held_reg <= held_next;
    end

    // RULE6: transparent pass
    assign q = strobe ? d : held_reg;

    a_latch_holds: assert property (  // RULE8
        @(posedge pclk) disable iff (!presetn)
        (!strobe && $past(!strobe)) |-> (q == $past(q)))
        else $error("latch output moved while closed");

endmodule // dmrc_fall_latch
`default_nettype wire

/* dmrc_pkg.sv */
// constants and types shared by the dram address mux / refresh controller
package dmrc_pkg;

    // clock and timing figures
    localparam int CLK_PERIOD_PS      = 5000;
    localparam int T_ROW_HOLD_NS      = 20;    // row address hold after row strobe
    localparam int T_COL_SETUP_NS     = 10;    // column valid before column strobe
    localparam int T_REF_PULSE_NS     = 80;    // auto refresh row strobe low time
    localparam int T_REF_INTERVAL_NS  = 15600; // auto refresh period
    // least times round up, the interval (a longest time) rounds down
    localparam logic [7:0] ROW_HOLD_CYC =
        8'((T_ROW_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] COL_SETUP_CYC =
        8'((T_COL_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] REF_PULSE_CYC =
        8'((T_REF_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [15:0] REF_INTERVAL_CYC =
        16'((T_REF_INTERVAL_NS * 1000) / CLK_PERIOD_PS);

    // widths
    localparam int ADDR_W = 9;
    localparam int BANKS  = 4;

    // register byte offsets
    localparam logic [11:0] CTRL_OFS     = 12'h000;
    localparam logic [11:0] STATUS_OFS   = 12'h004;
    localparam logic [11:0] INTERVAL_OFS = 12'h008;

    // control register fields
    localparam int CTRL_MODE_A_BIT = 0;
    localparam int CTRL_MODE_B_BIT = 1;
    localparam int CTRL_CLEAR_BIT  = 2;
    localparam logic [1:0] CTRL_MODE_RESET = 2'h0;

    // status register fields
    localparam int STAT_COUNT_LSB   = 0;
    localparam int STAT_STATE_LSB   = 12;
    localparam int STAT_PENDING_BIT = 16;

    // operating modes, coded {mode_select_b, mode_select_a}
    typedef enum logic [1:0] {
        MODE_EXT_REF  = 2'b00,
        MODE_AUTO_REF = 2'b01,
        MODE_EXT_ACC  = 2'b10,
        MODE_AUTO_ACC = 2'b11
    } dmrc_mode_t;

    // controller states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ROW  = 3'b001,
        ST_COL  = 3'b010,
        ST_REF  = 3'b011
    } dmrc_state_t;

endpackage

/* dmrc_refresh_counter.sv */
// refresh row counter, advanced once per finished refresh
`timescale 1ns/1ps
`default_nettype none
module dmrc_refresh_counter
    import dmrc_pkg::*;
#(
    parameter int W = 9
)
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // control
    input  wire logic         clear,
    input  wire logic         advance,
    // current row
    output logic      [W-1:0] count
);

    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;

    // RULE1: row counter
    always_comb
    begin
        if (clear)
            count_next = '0;
        else if (advance)
            count_next = count_reg + W'(1);
        else
            count_next = count_reg;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_reg <= '0;
        else
            count_reg <= count_next;
    end

    assign count = count_reg;

    a_count_step: assert property (  // RULE3
        @(posedge pclk) disable iff (!presetn)
        (advance && !clear) |=> (count == $past(count) + W'(1)))
        else $error("refresh counter did not step by one");

    a_count_still: assert property (  // RULE3
        @(posedge pclk) disable iff (!presetn)
        (!advance && !clear) |=> (count == $past(count)))
        else $error("refresh counter moved without a refresh");

endmodule // dmrc_refresh_counter
`default_nettype wire

/* dram_address_mux_refresh_ctrl_tb_top.sv */
// self-checking bench for the dram address mux and refresh controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("BAD %0t got %h expected %h", $time, (got), (exp)); \
        end \
    end
module dram_address_mux_refresh_ctrl_tb_top
    import dmrc_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic [8:0]  row_address_in, column_address_in, muxed_address_out;
    logic        bank_select_low, bank_select_high, address_latch_strobe;
    logic        chip_select_n, row_strobe_request_in_n, row_column_select;
    logic        column_strobe_request_in_n, write_request_in_n;
    logic [3:0]  row_strobe_out_n;
    logic        column_strobe_out_n, write_enable_out_n, err_v, cap_valid;
    logic [13:0] cap_data, exp_v;
    logic [13:0] exp_q[$];
    int          errors, check_count, n;

    dmrc_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .row_address_in(row_address_in),
        .column_address_in(column_address_in),
        .bank_select_low(bank_select_low),
        .bank_select_high(bank_select_high),
        .address_latch_strobe(address_latch_strobe),
        .chip_select_n(chip_select_n),
        .row_strobe_request_in_n(row_strobe_request_in_n),
        .column_strobe_request_in_n(column_strobe_request_in_n),
        .row_column_select(row_column_select),
        .write_request_in_n(write_request_in_n),
        .muxed_address_out(muxed_address_out),
        .row_strobe_out_n(row_strobe_out_n),
        .column_strobe_out_n(column_strobe_out_n),
        .write_enable_out_n(write_enable_out_n));

    dmrc_dram_model dram (.pclk(pclk), .presetn(presetn),
        .muxed_address_out(muxed_address_out),
        .row_strobe_out_n(row_strobe_out_n),
        .column_strobe_out_n(column_strobe_out_n),
        .cap_valid(cap_valid), .cap_data(cap_data));

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    task automatic test_done;
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // apb transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50)
        begin
            @(posedge pclk);
            k++;
        end
        `CHK(pready, 1'b1)
        rd_v = prdata;
        err_v = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // one access; open keeps latches transparent, ext times it by pins
    task automatic access(input logic [1:0] bank, input logic open,
                          input logic ext);
        logic [8:0] row, col;
        row = 9'($urandom);
        col = 9'($urandom);
        @(posedge pclk);
        row_address_in       <= row;
        column_address_in    <= col;
        {bank_select_high, bank_select_low} <= bank;
        address_latch_strobe <= 1'b1;
        write_request_in_n   <= 1'b0;
        row_column_select    <= 1'b1;
        @(posedge pclk);
        address_latch_strobe <= open;
        @(posedge pclk);
        if (!open)
        begin
            row_address_in    <= ~row;
            column_address_in <= ~col;
            {bank_select_high, bank_select_low} <= ~bank;
        end
        exp_q.push_back({1'b0, ~(4'h1 << bank), row});
        exp_q.push_back({1'b1, ~(4'h1 << bank), col});
        row_strobe_request_in_n <= 1'b0;
        if (ext)
        begin
            repeat (4) @(posedge pclk);
            row_column_select <= 1'b0;
            repeat (2) @(posedge pclk);
            column_strobe_request_in_n <= 1'b0;
        end
        n = 0;
        while (column_strobe_out_n !== 1'b0 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK(column_strobe_out_n, 1'b0)
        repeat (2) @(posedge pclk);
        `CHK(write_enable_out_n, 1'b0)
        row_strobe_request_in_n    <= 1'b1;
        column_strobe_request_in_n <= 1'b1;
        write_request_in_n         <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK(row_strobe_out_n, 4'hf)
        `CHK(write_enable_out_n, 1'b1)
    endtask

    // scoreboard: each strobe fall takes the oldest note
    always @(posedge pclk)
    begin
        if (presetn === 1'b1 && cap_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                errors++;
                $display("BAD %0t unexpected strobe %h", $time, cap_data);
            end
            else
            begin
                exp_v = exp_q.pop_front();
                `CHK(cap_data, exp_v)
            end
        end
    end

    // watchdog against a hang
    initial
    begin
        repeat (6000) @(posedge pclk);
        errors++;
        $display("BAD %0t timeout", $time);
        test_done();
    end

    // main sequence
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, address_latch_strobe} = '0;
        {paddr, pwdata, row_address_in, column_address_in} = '0;
        {bank_select_low, bank_select_high, row_column_select} = '0;
        {chip_select_n, row_strobe_request_in_n} = 2'b01;
        {column_strobe_request_in_n, write_request_in_n} = 2'b11;
        errors = 0;
        check_count = 0;
        void'($urandom(60));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK({row_strobe_out_n, column_strobe_out_n}, 5'h1f)
        `CHK(muxed_address_out, 9'h0)
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd_v, 32'h0)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK({err_v, rd_v}, 33'h1_0000_0000)
        apb(1'b1, INTERVAL_OFS, 32'hffff);
        apb(1'b1, CTRL_OFS, 32'h3);
        for (int b = 0; b < 4; b++)
            access(2'(b), b == 3, 1'b0);
        access(2'($urandom), 1'b0, 1'b0);
        // chip select high blocks an access
        chip_select_n <= 1'b1;
        row_strobe_request_in_n <= 1'b0;
        repeat (20) @(posedge pclk);
        `CHK(row_strobe_out_n, 4'hf)
        row_strobe_request_in_n <= 1'b1;
        chip_select_n <= 1'b0;
        apb(1'b1, CTRL_OFS, 32'h2);
        access(2'($urandom), 1'b0, 1'b1);
        // automatic refresh walks rows with chip select high
        for (int r = 0; r < 3; r++)
            exp_q.push_back({1'b0, 4'h0, 9'(r)});
        apb(1'b1, INTERVAL_OFS, 32'd20);
        chip_select_n <= 1'b1;
        apb(1'b1, CTRL_OFS, 32'h5);
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd_v, 32'h1)
        n = 0;
        while (exp_q.size() != 0 && n < 400)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK(exp_q.size(), 0)
        apb(1'b1, CTRL_OFS, 32'h0);
        repeat (30) @(posedge pclk);
        exp_q.push_back({1'b0, 4'h0, 9'd3});
        row_strobe_request_in_n <= 1'b0;
        repeat (6) @(posedge pclk);
        `CHK(column_strobe_out_n, 1'b1)
        row_strobe_request_in_n <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rd_v[8:0], 9'd4)
        `CHK(rd_v[16:12], 5'h0)
        `CHK(exp_q.size(), 0)
        test_done();
    end
endmodule // dram_address_mux_refresh_ctrl_tb_top
`default_nettype wire
